/* File: hw/display_attr_pkg.sv */
package display_attr_pkg;

  // Register map, byte addresses on the host register port
  localparam logic [15:0] POWER_SAVE_ADDR     = 16'h8008;
  localparam logic [15:0] DISPLAY_ENABLE_ADDR = 16'h8009;
  localparam logic [15:0] ATTRIBUTE_ADDR      = 16'h800a;

  // Reset values
  localparam logic [7:0] POWER_SAVE_RST     = 8'h01;
  localparam logic [7:0] DISPLAY_ENABLE_RST = 8'h00;
  localparam logic [7:0] ATTRIBUTE_RST      = 8'h00;
  localparam logic [7:0] READ_ZERO          = 8'h00;

  // Field positions
  localparam int POWER_SAVE_BIT    = 0;
  localparam int DISPLAY_ON_BIT    = 0;
  localparam int LAYER_THREE_LSB   = 6;
  localparam int LAYER_TWO_LSB     = 4;
  localparam int LAYER_ONE_LSB     = 2;
  localparam int CURSOR_LSB        = 0;
  localparam int ATTR_W            = 2;

  // Attribute encodings
  localparam logic [1:0] ATTR_BLANK  = 2'h0;
  localparam logic [1:0] ATTR_STEADY = 2'h1;
  localparam logic [1:0] ATTR_SLOW   = 2'h2;
  localparam logic [1:0] ATTR_FAST   = 2'h3;

  // Flash periods as log2 of frames per period
  localparam int LAYER_SLOW_LOG2  = 5;
  localparam int LAYER_FAST_LOG2  = 2;
  localparam int CURSOR_SLOW_LOG2 = 5;
  localparam int CURSOR_ALT_LOG2  = 6;

  // Share of each flash period spent visible, in percent
  localparam int LAYER_DUTY_PCT  = 50;
  localparam int CURSOR_DUTY_PCT = 70;

  localparam int FRAME_CNT_W_DEF = 6;
  localparam int CURSOR_ADDR_W   = 16;
  localparam logic [CURSOR_ADDR_W-1:0] CURSOR_ADDR_RST  = 16'h0000;
  localparam logic [CURSOR_ADDR_W-1:0] CURSOR_ADDR_STEP = 16'h0001;

endpackage : display_attr_pkg

/* File: hw/flash_timing_if.sv */
`timescale 1ns/10ps
interface flash_timing_if #(
  parameter int CNT_W = 6
);
  logic [CNT_W-1:0] frameCnt;
  logic             masterOn;

  modport source (output frameCnt, output masterOn);
  modport sink   (input frameCnt, input masterOn);
endinterface : flash_timing_if

/* File: hw/attr_gate.sv */
`timescale 1ns/10ps
module attr_gate
  import display_attr_pkg::*;
#(
  parameter int SLOW_LOG2 = LAYER_SLOW_LOG2,
  parameter int FAST_LOG2 = LAYER_FAST_LOG2,
  parameter int DUTY_PCT  = LAYER_DUTY_PCT
) (
  flash_timing_if.sink      tim,
  input  wire logic [1:0]   attr,
  output logic              show
);

  localparam int SLOW_P  = 1 << SLOW_LOG2;
  localparam int FAST_P  = 1 << FAST_LOG2;
  localparam int SLOW_TH = (SLOW_P * DUTY_PCT) / 100;
  localparam int FAST_TH = (FAST_P * DUTY_PCT) / 100;

  if (DUTY_PCT < 1 || DUTY_PCT > 99) begin : g_bad_duty
    $error("attr_gate: duty must lie between 1 and 99 percent");
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase within the selected flash period; visible in its early part
  always_comb begin
    int slowPhase;
    int fastPhase;
    slowPhase = int'(tim.frameCnt) & (SLOW_P - 1);
    fastPhase = int'(tim.frameCnt) & (FAST_P - 1);
    unique case (attr)
      ATTR_BLANK:  show = 1'b0;
      ATTR_STEADY: show = tim.masterOn;
      ATTR_SLOW:   show = tim.masterOn && (slowPhase < SLOW_TH);
      ATTR_FAST:   show = tim.masterOn && (fastPhase < FAST_TH);
    endcase
  end

endmodule : attr_gate

/* File: hw/display_layer_attribute_control.sv */
// What this block does
// - Power save active forces the master display enable bit to zero.
// - Display switch command uses the displaySwitchOn input as its parameter.
// - Enable bit 0 switches whole output: cursor and every layer.
// - Master enable clear hides everything regardless of attribute fields.
// - Bits 7-6 layer three: blank, steady, flash frame/32, flash frame/4.
// - Bits 5-4 layer two: same four-way encoding as layer three.
// - In dual-panel mode layer four follows the layer two setting.
// - Bits 3-2 layer one: same four-way encoding.
// - Bits 1-0 cursor: hidden, steady, flash frame/32, flash frame/64.
// - Flashing cursor visible 22 of 32 or 44 of 64 frames of each flash period (70 percent rounded down).
// - Memory write re-enables a disabled cursor and advances its address.
// - Memory read advances cursor address, leaves disabled cursor disabled.
// - Enable and attribute registers reset to zero.
// - Power save bit resets to one, so display starts off.
`timescale 1ns/10ps
module display_layer_attribute_control
  import display_attr_pkg::*;
#(
  parameter int FRAME_CNT_W = FRAME_CNT_W_DEF
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [15:0]              regAddr,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  input  wire logic [7:0]               regWdata,
  output logic      [7:0]               regRdata,
  input  wire logic                     displaySwitchCommand,
  input  wire logic                     displaySwitchOn,
  input  wire logic                     dualPanel,
  input  wire logic                     frameStart,
  input  wire logic                     memWrite,
  input  wire logic                     memRead,
  input  wire logic                     cursorLoad,
  input  wire logic [CURSOR_ADDR_W-1:0] cursorLoadAddr,
  output logic                          displayOn,
  output logic                          powerSave,
  output logic                          layerOneShow,
  output logic                          layerTwoShow,
  output logic                          layerThreeShow,
  output logic                          layerFourShow,
  output logic                          cursorShow,
  output logic      [CURSOR_ADDR_W-1:0] cursorAddr
);

  if (FRAME_CNT_W < CURSOR_ALT_LOG2) begin : g_bad_cnt
    $error("frame counter too narrow for the slowest flash period");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic                     powerSave_q, powerSave_d;
  logic                     enable_q, enable_d;
  logic [7:0]               attr_q, attr_d;
  logic [7:0]               rdata_q, rdata_d;
  logic [CURSOR_ADDR_W-1:0] cursorAddr_q, cursorAddr_d;
  logic [FRAME_CNT_W-1:0]   frameCnt_q, frameCnt_d;

  logic wrPower, wrEnable, wrAttr;

  assign wrPower  = regWrite && (regAddr == POWER_SAVE_ADDR);
  assign wrEnable = regWrite && (regAddr == DISPLAY_ENABLE_ADDR);
  assign wrAttr   = regWrite && (regAddr == ATTRIBUTE_ADDR);

  always_comb begin
    logic [7:0] attrNext;
    attrNext    = attr_q;
    powerSave_d = powerSave_q;
    enable_d    = enable_q;

    if (wrPower) begin
      powerSave_d = regWdata[POWER_SAVE_BIT];
    end

    // Only a host write or a command turns the display on
    if (wrEnable) begin
      enable_d = regWdata[DISPLAY_ON_BIT];
    end
    if (displaySwitchCommand) begin
      enable_d = displaySwitchOn;
    end
    // Power save wins over any enable request in the same cycle
    if (powerSave_d) begin
      enable_d = 1'b0;
    end

    if (wrAttr) begin
      attrNext = regWdata;
    end
    // Register write is applied first so a same-cycle memory write still re-enables
    if (memWrite && attrNext[CURSOR_LSB +: ATTR_W] == ATTR_BLANK) begin
      attrNext[CURSOR_LSB +: ATTR_W] = ATTR_STEADY;
    end
    attr_d = attrNext;
  end

  always_comb begin
    rdata_d = rdata_q;
    if (regRead) begin
      unique case (regAddr)
        POWER_SAVE_ADDR:     rdata_d = {7'h00, powerSave_q};
        DISPLAY_ENABLE_ADDR: rdata_d = {7'h00, enable_q};
        ATTRIBUTE_ADDR:      rdata_d = attr_q;
        default:             rdata_d = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerSave_q <= POWER_SAVE_RST[POWER_SAVE_BIT];
      enable_q    <= DISPLAY_ENABLE_RST[DISPLAY_ON_BIT];
      attr_q      <= ATTRIBUTE_RST;
      rdata_q     <= READ_ZERO;
    end else begin
      powerSave_q <= powerSave_d;
      enable_q    <= enable_d;
      attr_q      <= attr_d;
      rdata_q     <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cursor address; load has priority over auto-advance
  always_comb begin
    cursorAddr_d = cursorAddr_q;
    if (cursorLoad) begin
      cursorAddr_d = cursorLoadAddr;
    end else if (memWrite || memRead) begin
      cursorAddr_d = cursorAddr_q + CURSOR_ADDR_STEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cursorAddr_q <= CURSOR_ADDR_RST;
    end else begin
      cursorAddr_q <= cursorAddr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame counter; steps only on frameStart and wraps freely, so flash phases only move at frame starts
  always_comb begin
    frameCnt_d = frameCnt_q;
    if (frameStart) begin
      frameCnt_d = frameCnt_q + FRAME_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameCnt_q <= '0;
    end else begin
      frameCnt_q <= frameCnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-layer gating
  flash_timing_if #(.CNT_W(FRAME_CNT_W)) timing ();

  assign timing.frameCnt = frameCnt_q;
  assign timing.masterOn = enable_q;

  logic layerOneNext, layerTwoNext, layerThreeNext, layerFourNext, cursorNext;

  // Layer four exists only in dual-panel drive and has no field of its own
  assign layerFourNext = dualPanel && layerTwoNext;

  attr_gate #(
    .SLOW_LOG2 (LAYER_SLOW_LOG2),
    .FAST_LOG2 (LAYER_FAST_LOG2),
    .DUTY_PCT  (LAYER_DUTY_PCT)
  ) u_layer_one (
    .tim  (timing),
    .attr (attr_q[LAYER_ONE_LSB +: ATTR_W]),
    .show (layerOneNext)
  );

  attr_gate #(
    .SLOW_LOG2 (LAYER_SLOW_LOG2),
    .FAST_LOG2 (LAYER_FAST_LOG2),
    .DUTY_PCT  (LAYER_DUTY_PCT)
  ) u_layer_two (
    .tim  (timing),
    .attr (attr_q[LAYER_TWO_LSB +: ATTR_W]),
    .show (layerTwoNext)
  );

  attr_gate #(
    .SLOW_LOG2 (LAYER_SLOW_LOG2),
    .FAST_LOG2 (LAYER_FAST_LOG2),
    .DUTY_PCT  (LAYER_DUTY_PCT)
  ) u_layer_three (
    .tim  (timing),
    .attr (attr_q[LAYER_THREE_LSB +: ATTR_W]),
    .show (layerThreeNext)
  );

  attr_gate #(
    .SLOW_LOG2 (CURSOR_SLOW_LOG2),
    .FAST_LOG2 (CURSOR_ALT_LOG2),
    .DUTY_PCT  (CURSOR_DUTY_PCT)
  ) u_cursor (
    .tim  (timing),
    .attr (attr_q[CURSOR_LSB +: ATTR_W]),
    .show (cursorNext)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output registers; one cycle behind the register state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      layerOneShow   <= 1'b0;
      layerTwoShow   <= 1'b0;
      layerThreeShow <= 1'b0;
      layerFourShow  <= 1'b0;
      cursorShow     <= 1'b0;
    end else begin
      layerOneShow   <= layerOneNext;
      layerTwoShow   <= layerTwoNext;
      layerThreeShow <= layerThreeNext;
      layerFourShow  <= layerFourNext;
      cursorShow     <= cursorNext;
    end
  end

  assign regRdata   = rdata_q;
  assign displayOn  = enable_q;
  assign powerSave  = powerSave_q;
  assign cursorAddr = cursorAddr_q;

endmodule : display_layer_attribute_control

/* File: sim/display_attr_assertions.sv */
`timescale 1ns/10ps
module display_attr_assertions
  import display_attr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] regAddr,
  input wire logic        regWrite,
  input wire logic [7:0]  regWdata,
  input wire logic        displaySwitchCommand,
  input wire logic        displaySwitchOn,
  input wire logic        dualPanel,
  input wire logic        frameStart,
  input wire logic        memWrite,
  input wire logic        memRead,
  input wire logic        cursorLoad,
  input wire logic        displayOn,
  input wire logic        powerSave,
  input wire logic        layerOneShow,
  input wire logic        layerTwoShow,
  input wire logic        layerThreeShow,
  input wire logic        layerFourShow,
  input wire logic        cursorShow,
  input wire logic [15:0] cursorAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  reset_state_a: assert property (disable iff (1'b0) rst |-> powerSave && !displayOn)
    else $error("bad reset state");
  save_clears_a: assert property (powerSave |-> !displayOn)
    else $error("enable kept in power save");
  no_self_on_a: assert property (!displayOn && !displaySwitchCommand
    && !(regWrite && regAddr == DISPLAY_ENABLE_ADDR) |=> !displayOn) else $error("enable set by itself");
  master_gate_a: assert property (!displayOn |=>
    !(layerOneShow || layerTwoShow || layerThreeShow || layerFourShow || cursorShow)) else $error("shown while off");
  quad_follow_a: assert property (dualPanel |=> layerFourShow == layerTwoShow)
    else $error("layer four differs");
  quad_off_a: assert property (!dualPanel |=> !layerFourShow)
    else $error("layer four without dual");
  cmd_param_a: assert property (displaySwitchCommand && !powerSave && !regWrite |=>
    displayOn == $past(displaySwitchOn)) else $error("command ignored");
  en_write_a: assert property (regWrite && regAddr == DISPLAY_ENABLE_ADDR && !powerSave
    && !displaySwitchCommand |=> displayOn == $past(regWdata[0])) else $error("enable write lost");
  cursor_step_a: assert property ((memRead || memWrite) && !cursorLoad |=>
    cursorAddr == $past(cursorAddr) + CURSOR_ADDR_STEP) else $error("cursor not advanced");
  frame_paced_a: assert property ($changed(layerOneShow) |-> $past(frameStart, 2)
    || $past(regWrite, 2) || $past(regWrite, 3) || $past(displaySwitchCommand, 2)) else $error("show moved off frame");
endmodule : display_attr_assertions

bind display_layer_attribute_control display_attr_assertions chk_u (.*);

/* File: sim/frame_source.sv */
`timescale 1ns/10ps
module frame_source #(
  parameter int GAP = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      frameStart
);
  int cnt_q;

  // Short frames keep the flash sweeps cheap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q      <= 0;
      frameStart <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      frameStart <= (cnt_q == GAP - 1);
    end
  end
endmodule : frame_source

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import display_attr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regWdata = 8'h00;
  logic        displaySwitchCommand = 1'b0;
  logic        displaySwitchOn = 1'b0;
  logic        dualPanel = 1'b0;
  logic        memWrite = 1'b0;
  logic        memRead = 1'b0;
  logic        cursorLoad = 1'b0;
  logic [15:0] cursorLoadAddr = 16'h0000;
  logic [7:0]  regRdata;
  logic [15:0] cursorAddr;
  logic        frameStart, displayOn, powerSave, cursorShow;
  logic        layerOneShow, layerTwoShow, layerThreeShow, layerFourShow;
  logic [4:0]  shows;
  int          n_fail = 0;
  int          n_checks = 0;

  assign shows = {layerOneShow, layerTwoShow, layerThreeShow, layerFourShow, cursorShow};
  always #5 clk = ~clk;
  frame_source frame_u (.clk, .rst, .frameStart);
  display_layer_attribute_control dut_u (.*);

  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(logic [15:0] a, logic [7:0] exp, string nm);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(nm, regRdata, exp);
  endtask : rd

  task automatic cmd(logic on, logic [4:0] expShows);
    @(posedge clk);
    displaySwitchOn      <= on;
    displaySwitchCommand <= 1'b1;
    @(posedge clk);
    displaySwitchCommand <= 1'b0;
    tick(3);
    chk("cmd_shows", shows, expShows);
  endtask : cmd

  // Lands a few cycles after a frame marker, once shows have settled
  task automatic wait_frame;
    int k;
    k = 0;
    while (frameStart !== 1'b1) begin
      k++;
      if (k > 20) begin
        n_fail++;
        tally_and_finish();
      end
      tick(1);
    end
    tick(5);
  endtask : wait_frame

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    tick(1);
    chk("save_out", powerSave, 1'b1);
    chk("on_out", displayOn, 1'b0);
    chk("shows_rst", shows, 5'h00);
    rd(POWER_SAVE_ADDR, POWER_SAVE_RST, "save_reg");
    rd(DISPLAY_ENABLE_ADDR, 8'h00, "en_reg");
    rd(ATTRIBUTE_ADDR, 8'h00, "attr_reg");
    wr(16'h800b, 8'hff);
    rd(16'h800b, 8'h00, "unmapped");
    $display("reset test done");
  endtask : t_reset

  task automatic t_master;
    wr(DISPLAY_ENABLE_ADDR, 8'h01);
    tick(2);
    chk("on_in_save", displayOn, 1'b0);
    wr(POWER_SAVE_ADDR, 8'h00);
    wr(DISPLAY_ENABLE_ADDR, 8'h01);
    wr(ATTRIBUTE_ADDR, 8'h55);
    dualPanel <= 1'b1;
    tick(3);
    chk("all_steady", shows, 5'h1f);
    wr(DISPLAY_ENABLE_ADDR, 8'h00);
    tick(3);
    chk("gated", shows, 5'h00);
    wr(DISPLAY_ENABLE_ADDR, 8'h01);
    wr(POWER_SAVE_ADDR, 8'h01);
    wr(POWER_SAVE_ADDR, 8'h00);
    tick(3);
    chk("stays_off", displayOn, 1'b0);
    rd(DISPLAY_ENABLE_ADDR, 8'h00, "en_cleared");
    $display("master test done");
  endtask : t_master

  // Full 64-frame sweep per code: visible frames and rising edges
  task automatic t_flash;
    int visL[4] = '{0, 64, 32, 32};
    int risL[4] = '{0, 0, 2, 16};
    int visC[4] = '{0, 64, 44, 44};
    int risC[4] = '{0, 0, 2, 1};
    int vis[5];
    int ris[5];
    logic [4:0] prev;
    wr(DISPLAY_ENABLE_ADDR, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(ATTRIBUTE_ADDR, {4{c[1:0]}});
      wait_frame();
      prev = shows;
      vis  = '{default: 0};
      ris  = '{default: 0};
      for (int i = 0; i < 64; i++) begin
        wait_frame();
        for (int j = 0; j < 5; j++) begin
          vis[j] += shows[j];
          ris[j] += shows[j] & ~prev[j];
        end
        prev = shows;
      end
      for (int j = 1; j < 5; j++) begin
        chk("layer_vis", vis[j], visL[c]);
        chk("layer_rise", ris[j], risL[c]);
      end
      chk("cursor_vis", vis[0], visC[c]);
      chk("cursor_rise", ris[0], risC[c]);
    end
    $display("flash test done");
  endtask : t_flash

  task automatic t_cursor;
    wr(ATTRIBUTE_ADDR, 8'h00);
    cursorLoadAddr <= 16'hfffe;
    cursorLoad     <= 1'b1;
    @(posedge clk);
    cursorLoad <= 1'b0;
    memRead    <= 1'b1;
    @(posedge clk);
    memRead <= 1'b0;
    tick(2);
    chk("rd_step", cursorAddr, 16'hffff);
    rd(ATTRIBUTE_ADDR, 8'h00, "rd_keeps_off");
    @(posedge clk);
    memWrite <= 1'b1;
    @(posedge clk);
    memWrite <= 1'b0;
    tick(3);
    chk("wr_wrap", cursorAddr, 16'h0000);
    chk("wr_shows", cursorShow, 1'b1);
    rd(ATTRIBUTE_ADDR, 8'h01, "wr_enables");
    $display("cursor test done");
  endtask : t_cursor

  task automatic t_command;
    cmd(1'b0, 5'h00);
    cmd(1'b1, 5'h01);
    wr(ATTRIBUTE_ADDR, 8'h55);
    dualPanel <= 1'b0;
    tick(3);
    chk("quad_off", shows, 5'h1d);
    wr(POWER_SAVE_ADDR, 8'h01);
    cmd(1'b1, 5'h00);
    $display("command test done");
  endtask : t_command

  initial begin
    // Raised by NBA so the reset flops see a real edge at time zero
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_flash();
    t_cursor();
    t_command();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    tally_and_finish();
  end
endmodule : tb_top
